// [scm_pkg.sv]
// Constants, field layouts and state types of the serial control master.
// Assumes a 250 MHz core clock and an open-drain two-wire bus with pull-ups.
package scm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4; // Core clock period
  localparam int T_LOW_NS = 1300; // Least low time of the serial clock
  localparam int QTR_CYC = (T_LOW_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Quarter bit, rounded up
  localparam int TICK_W = 8; // Width of the quarter-bit counter

  // ----------------------------------------------------------------
  // Bus protocol
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h44; // Target address 1000100
  localparam logic DIR_WR = 1'h0; // Direction bit for a write
  localparam logic DIR_RD = 1'h1; // Direction bit for a read
  localparam logic [3:0] BIT_ACK = 4'h8; // Index of the acknowledge bit
  localparam logic [1:0] BYTE_ADDR = 2'h0; // Address byte with write bit
  localparam logic [1:0] BYTE_REG = 2'h1; // Register index byte
  localparam logic [1:0] BYTE_THIRD = 2'h2; // Write data or read address byte
  localparam logic [1:0] BYTE_RDATA = 2'h3; // Data byte returned by the target
  localparam logic [7:0] LAST_RW_IDX = 8'h0d; // Highest writable register
  localparam logic [7:0] RO_IDX = 8'h0f; // Read-only level register

  // ----------------------------------------------------------------
  // Software register map
  // ----------------------------------------------------------------
  localparam int BUS_ADDR_W = 4; // Byte address width
  localparam logic [3:0] OFF_CMD = 4'h0; // Command register
  localparam logic [3:0] OFF_STAT = 4'h4; // Status register
  localparam logic [3:0] OFF_PIN = 4'h8; // Pin control register
  localparam int CMD_IDX_LSB = 0; // Register index field
  localparam int CMD_DATA_LSB = 8; // Write data field
  localparam int CMD_RD_BIT = 16; // 1 = read transfer
  localparam int ST_BUSY_BIT = 0; // Transfer running
  localparam int ST_NACK_BIT = 1; // Target refused a byte
  localparam int ST_DONE_BIT = 2; // Last command finished
  localparam int ST_BADIDX_BIT = 3; // Last command refused locally
  localparam int ST_RDATA_LSB = 8; // Byte read back
  localparam int PIN_OFF_BIT = 0; // Level of the output-off pin
  localparam int PIN_GUARD_BIT = 1; // Refuse commands while the pin is high

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_COND, ST_BITS, ST_FREE} scm_state_t;
  typedef enum logic [1:0] {CD_START, CD_RSTART, CD_STOP} scm_cond_t;

endpackage : scm_pkg

// [scm_master.sv]
// Two-wire bus master that reads and writes the amplifier's control registers.
// Assumes pull-ups on both lines and a target that never stretches the clock.
//
// Overview of operation
// - Address 1000100, direction bit 0 write.
// - Start, address, index, data, then stop.
// - One data byte per transfer, acknowledged; the master leaves a read data byte unacknowledged.
// - Start: data falls while clock high.
// - Stop: data rises while clock high.
// - Repeated start may replace stop.
// - Receiver holds data low through acknowledge; the master leaves it high after the read data byte.
// - Unacknowledged address leaves line high; stop.
// - Later refused byte: master aborts with stop.
// - Master makes clock, starts and stops.
// - Software writes 0x81 or 0x85 there.
`timescale 1ns/10ps
`default_nettype none

module scm_master
  import scm_pkg::*;
#(
  parameter int QTR = QTR_CYC // Cycles per quarter bit
)(
  input wire logic core_clk_i, // Core clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic [scm_pkg::BUS_ADDR_W-1:0] bus_addr_i, // Register byte address
  input wire logic [31:0] bus_wdata_i, // Write data
  input wire logic bus_wr_i, // Write strobe
  input wire logic bus_rd_i, // Read strobe
  output logic [31:0] bus_rdata_o, // Read data, cycle after strobe
  output logic scl_o, // Clock line output level
  output logic scl_oe_o, // Clock line pulled low
  input wire logic sda_i, // Data line level
  output logic sda_o, // Data line output level
  output logic sda_oe_o, // Data line pulled low
  output logic output_off_pin_o // Output-off pin of the target
);
  import scm_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  scm_state_t st_r, st_nxt; // Engine state
  scm_cond_t cond_r, cond_nxt; // Which bus condition is made
  logic [1:0] ph_r, ph_nxt; // Quarter within a bit or condition
  logic [TICK_W-1:0] tick_r, tick_nxt; // Quarter-bit counter
  logic [3:0] bit_r, bit_nxt; // Bit within a byte, 8 = acknowledge
  logic [1:0] byte_r, byte_nxt; // Byte within the transfer
  logic [7:0] shift_r, shift_nxt; // Byte shifting out or in
  logic ack_r, ack_nxt; // Acknowledge seen on the last byte
  logic rd_r, rd_nxt; // Transfer is a read
  logic [7:0] idx_r, idx_nxt; // Target register index
  logic [7:0] data_r, data_nxt; // Data to write
  logic [7:0] rbuf_r, rbuf_nxt; // Byte read back
  logic nack_r, nack_nxt; // Target refused a byte
  logic done_r, done_nxt; // Command finished
  logic badidx_r, badidx_nxt; // Command refused locally
  logic scl_oe_r, scl_oe_nxt; // Clock line pull
  logic sda_oe_r, sda_oe_nxt; // Data line pull
  logic sda_s1_r, sda_s2_r; // Data line synchroniser
  logic off_r, off_nxt; // Output-off pin level
  logic guard_r, guard_nxt; // Refuse commands while pin high
  logic [31:0] rdata_r, rdata_nxt; // Read data register
  logic tick_done; // Quarter bit elapsed
  logic cmd_go; // Command write seen
  logic cmd_rd; // Command asks for a read
  logic [7:0] cmd_idx; // Command register index
  logic idx_ok; // Index legal for the direction
  logic rx; // Current byte comes from the target

  // Byte sent in each slot of the transfer
  function automatic logic [7:0] byte_val(input logic [1:0] b, input logic rd, input logic [7:0] idx,
                                          input logic [7:0] dat);
    logic [7:0] v;
    v = 8'hff;
    unique case (b)
      BYTE_ADDR: v = {DEV_ADDR, DIR_WR};
      BYTE_REG: v = idx;
      BYTE_THIRD: v = rd ? {DEV_ADDR, DIR_RD} : dat;
      BYTE_RDATA: v = 8'hff; // Line released while the target sends
    endcase
    return v;
  endfunction : byte_val

  assign tick_done = (tick_r == TICK_W'(QTR - 1));
  assign cmd_go = bus_wr_i && (bus_addr_i == OFF_CMD);
  assign cmd_rd = bus_wdata_i[CMD_RD_BIT];
  assign cmd_idx = bus_wdata_i[CMD_IDX_LSB +: 8];
  assign idx_ok = (cmd_idx <= LAST_RW_IDX) || (cmd_rd && cmd_idx == RO_IDX);
  assign rx = rd_r && (byte_r == BYTE_RDATA);

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // Next state of the engine and of the two line pulls
  always_comb
  begin
    st_nxt = st_r;
    cond_nxt = cond_r;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    shift_nxt = shift_r;
    ack_nxt = ack_r;
    rd_nxt = rd_r;
    idx_nxt = idx_r;
    data_nxt = data_r;
    rbuf_nxt = rbuf_r;
    nack_nxt = nack_r;
    done_nxt = done_r;
    badidx_nxt = badidx_r;
    tick_nxt = (st_r == ST_IDLE || tick_done) ? '0 : tick_r + TICK_W'(1);
    unique case (st_r)
      ST_IDLE:
      begin
        // Accept a command; refuse it on an illegal index or while guard and pin are both high
        if (cmd_go)
        begin
          if (!idx_ok || (guard_r && off_r))
          begin
            badidx_nxt = 1'b1;
            done_nxt = 1'b1;
          end
          else
          begin
            rd_nxt = cmd_rd;
            idx_nxt = cmd_idx;
            data_nxt = bus_wdata_i[CMD_DATA_LSB +: 8];
            nack_nxt = 1'b0;
            badidx_nxt = 1'b0;
            done_nxt = 1'b0;
            st_nxt = ST_COND;
            cond_nxt = CD_START;
            ph_nxt = 2'h0;
            byte_nxt = BYTE_ADDR;
            bit_nxt = 4'h0;
          end
        end
      end
      ST_COND:
      begin
        // Four quarters per condition, then bits or bus-free wait
        if (tick_done)
        begin
          ph_nxt = ph_r + 2'h1;
          if (ph_r == 2'h3)
          begin
            if (cond_r == CD_STOP)
              st_nxt = ST_FREE;
            else
            begin
              st_nxt = ST_BITS;
              bit_nxt = 4'h0;
              shift_nxt = byte_val(byte_r, rd_r, idx_r, data_r);
            end
          end
        end
      end
      ST_BITS:
      begin
        if (tick_done)
        begin
          ph_nxt = ph_r + 2'h1;
          // Sample in the middle of the high phase
          if (ph_r == 2'h2)
          begin
            if (bit_r == BIT_ACK)
              ack_nxt = !sda_s2_r;
            else if (rx)
              shift_nxt = {shift_r[6:0], sda_s2_r};
          end
          if (ph_r == 2'h3)
          begin
            if (bit_r != BIT_ACK)
            begin
              bit_nxt = bit_r + 4'h1;
              if (!rx)
                shift_nxt = {shift_r[6:0], 1'b0};
            end
            else
            begin
              bit_nxt = 4'h0;
              if (rx)
              begin
                // Data byte taken and not acknowledged by the master
                rbuf_nxt = shift_r;
                st_nxt = ST_COND;
                cond_nxt = CD_STOP;
              end
              else if (!ack_r)
              begin
                // Target refused a byte: abort
                nack_nxt = 1'b1;
                st_nxt = ST_COND;
                cond_nxt = CD_STOP;
              end
              else if (rd_r && byte_r == BYTE_REG)
              begin
                byte_nxt = BYTE_THIRD;
                st_nxt = ST_COND;
                cond_nxt = CD_RSTART;
              end
              else if (!rd_r && byte_r == BYTE_THIRD)
              begin
                st_nxt = ST_COND;
                cond_nxt = CD_STOP;
              end
              else
              begin
                byte_nxt = byte_r + 2'h1;
                shift_nxt = byte_val(byte_nxt, rd_r, idx_r, data_r);
              end
            end
          end
        end
      end
      ST_FREE:
      begin
        // Two quarters of free bus after the stop
        if (tick_done)
        begin
          ph_nxt = ph_r + 2'h1;
          if (ph_r == 2'h1)
          begin
            st_nxt = ST_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
    endcase
    // Line pulls for the quarter being entered
    scl_oe_nxt = 1'b0;
    sda_oe_nxt = 1'b0;
    if (st_nxt == ST_BITS)
    begin
      scl_oe_nxt = !ph_nxt[1];
      sda_oe_nxt = sda_oe_r;
      if (ph_nxt == 2'h1)
        sda_oe_nxt = (bit_r != BIT_ACK && !rx) ? !shift_r[7] : 1'b0;
    end
    else if (st_nxt == ST_COND)
    begin
      unique case (cond_nxt)
        CD_START:
          sda_oe_nxt = ph_nxt[1];
        CD_RSTART:
        begin
          scl_oe_nxt = !ph_nxt[1];
          sda_oe_nxt = (ph_nxt == 2'h3);
        end
        CD_STOP:
        begin
          scl_oe_nxt = !ph_nxt[1];
          sda_oe_nxt = (ph_nxt == 2'h1) || (ph_nxt == 2'h2);
        end
      endcase
    end
  end

  // Engine registers and data line synchroniser
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= ST_IDLE;
      cond_r <= CD_START;
      ph_r <= 2'h0;
      tick_r <= '0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      idx_r <= 8'h00;
      data_r <= 8'h00;
      rbuf_r <= 8'h00;
      nack_r <= 1'b0;
      done_r <= 1'b0;
      badidx_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      cond_r <= cond_nxt;
      ph_r <= ph_nxt;
      tick_r <= tick_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      shift_r <= shift_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      idx_r <= idx_nxt;
      data_r <= data_nxt;
      rbuf_r <= rbuf_nxt;
      nack_r <= nack_nxt;
      done_r <= done_nxt;
      badidx_r <= badidx_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Pin control writes and read data mux
  always_comb
  begin
    off_nxt = off_r;
    guard_nxt = guard_r;
    rdata_nxt = 32'h0;
    if (bus_wr_i && bus_addr_i == OFF_PIN)
    begin
      off_nxt = bus_wdata_i[PIN_OFF_BIT];
      guard_nxt = bus_wdata_i[PIN_GUARD_BIT];
    end
    if (bus_rd_i)
    begin
      unique case (bus_addr_i)
        OFF_CMD:
        begin
          rdata_nxt[CMD_IDX_LSB +: 8] = idx_r;
          rdata_nxt[CMD_DATA_LSB +: 8] = data_r;
          rdata_nxt[CMD_RD_BIT] = rd_r;
        end
        OFF_STAT:
        begin
          rdata_nxt[ST_BUSY_BIT] = (st_r != ST_IDLE);
          rdata_nxt[ST_NACK_BIT] = nack_r;
          rdata_nxt[ST_DONE_BIT] = done_r;
          rdata_nxt[ST_BADIDX_BIT] = badidx_r;
          rdata_nxt[ST_RDATA_LSB +: 8] = rbuf_r;
        end
        OFF_PIN:
        begin
          rdata_nxt[PIN_OFF_BIT] = off_r;
          rdata_nxt[PIN_GUARD_BIT] = guard_r;
        end
        default: rdata_nxt = 32'h0; // Unmapped reads as zero
      endcase
    end
  end

  // Software register storage
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      off_r <= 1'b0;
      guard_r <= 1'b0;
      rdata_r <= 32'h0;
    end
    else
    begin
      off_r <= off_nxt;
      guard_r <= guard_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata_o = rdata_r;
  assign scl_oe_o = scl_oe_r;
  assign sda_oe_o = sda_oe_r;
  assign output_off_pin_o = off_r;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_idle_bus_free: assert property (st_r == ST_IDLE |-> !scl_oe_r && !sda_oe_r)
    else $error("bus not released while idle");
  a_start_shape: assert property ($rose(sda_oe_r) && !scl_oe_r |-> st_r == ST_COND && cond_r != CD_STOP)
    else $error("data pulled low with clock high outside a start");
  a_stop_shape: assert property ($fell(sda_oe_r) && !scl_oe_r |-> st_r == ST_COND && cond_r == CD_STOP)
    else $error("data released with clock high outside a stop");
  a_data_stable: assert property (st_r == ST_BITS && $changed(sda_oe_r) |-> scl_oe_r && ph_r == 2'h1)
    else $error("data changed while clock high");
  a_ack_release: assert property (st_r == ST_BITS && bit_r == BIT_ACK && !scl_oe_r |-> !sda_oe_r)
    else $error("master drives data during acknowledge");
  a_rx_release: assert property (st_r == ST_BITS && rx && !scl_oe_r |-> !sda_oe_r)
    else $error("master drives data while target sends");
  a_addr_msb: assert property (st_r == ST_BITS && byte_r == BYTE_ADDR && bit_r == 4'h0 && !scl_oe_r
                               |-> sda_oe_r == !DEV_ADDR[6])
    else $error("wrong first address bit");
  a_nack_stop: assert property ($rose(nack_r) |-> st_r == ST_COND && cond_r == CD_STOP && scl_oe_r)
    else $error("refused byte not followed by stop");
  a_refuse_bad: assert property (st_r == ST_IDLE && cmd_go && !idx_ok |=> st_r == ST_IDLE && badidx_r)
    else $error("illegal index not refused");
  a_guard_hold: assert property (st_r == ST_IDLE && cmd_go && guard_r && off_r |=> st_r == ST_IDLE)
    else $error("transfer started while target ignores clock");
  a_rstart_read: assert property (st_r == ST_COND && cond_r == CD_RSTART |-> rd_r && byte_r == BYTE_THIRD)
    else $error("repeated start outside a read");

endmodule : scm_master

`default_nettype wire

// [scm_dev_model.sv]
// Behavioural model of the amplifier's two-wire control port and registers.
// Assumes resolved open-drain wire levels with pull-ups; the bench resolves them.
`timescale 1ns/10ps
`default_nettype none

module scm_dev_model #(
  parameter logic [6:0] DEF_LEVEL = 7'h19 // Fixed assert level, arbitrary value
)(
  input wire logic scl_i, // Clock wire level
  input wire logic sda_i, // Data wire level
  input wire logic output_off_pin_i, // Output-off pin
  input wire logic [1:0] refuse_i, // 1 addr, 2 index, 3 data refused
  output logic sda_oe_o // High pulls data low
);
  // ----------------------------------------------------------------
  // Registers and bit engine state
  // ----------------------------------------------------------------
  logic [7:0] regs [0:15]; // Register file
  logic [7:0] shreg; // Incoming byte
  logic [7:0] idx; // Selected register
  logic [7:0] last_addr; // Last address byte seen
  logic [7:0] tx; // Byte being returned
  logic act, rd, scl_q, sda_q, ack; // Engine flags
  int bitcnt, byte_no; // Bit and byte position
  wire logic gated = regs[0][5] & output_off_pin_i; // Clock ignored
  // Settings the analogue side would act on, decoded from the register file
  wire logic offset_cancel_off = regs[0][1]; // Offset loop off
  wire logic output_invert = regs[0][4]; // Output polarity swapped
  wire logic absent_range_high = regs[0][2]; // High assert range
  wire logic slice_adjust_on = (regs[1] != 8'h00); // Threshold adjust powered
  wire logic [1:0] slice_span_code = regs[2][5:4]; // Threshold shift span
  wire logic [3:0] deemph_code = regs[2][3:0]; // De-emphasis steps
  wire logic rx_tuning_apply = regs[7][7]; // Tuning fields in use
  wire logic [1:0] rx_tuning_code = regs[7][3:2]; // Equalisation choice
  wire logic [2:0] output_swing_code = regs[3][2:0]; // Output swing
  wire logic rise_mask_enable = regs[13][7]; // Rising edge mask on
  wire logic fall_mask_enable = regs[12][7]; // Falling edge mask on
  wire logic [15:0] rise_mask_us = 16'(regs[13][6:0]) * 16'h0020; // Rising mask length
  wire logic [15:0] fall_mask_us = 16'(regs[12][6:0]) * 16'h0020; // Falling mask length

  initial
  begin
    foreach (regs[i]) regs[i] = 8'h00;
    regs[3] = 8'h02; // Default swing code
    {sda_oe_o, act, rd, scl_q, sda_q} = 5'b00011;
    {bitcnt, byte_no} = 0;
  end

  // Level register reflects the source bit
  always @*
  begin
    if (idx == 8'h0f)
      tx = {1'b0, regs[11][7] ? regs[11][6:0] : DEF_LEVEL};
    else
      tx = regs[idx[3:0]];
  end

  // ----------------------------------------------------------------
  // Wire edges: conditions, sampling and driving
  // ----------------------------------------------------------------
  always @(scl_i or sda_i)
  begin
    if (scl_i && scl_q && sda_q && !sda_i)
    begin
      // Start or repeated start opens a new transfer
      {act, rd, sda_oe_o} = 3'b100;
      {bitcnt, byte_no} = 0;
    end
    else if (scl_i && scl_q && !sda_q && sda_i)
    begin
      // Stop ends the transfer
      {act, sda_oe_o} = 2'b00;
    end
    else if (act && !gated && scl_i && !scl_q)
    begin
      // Sample MSB first, then step past the acknowledge
      if (bitcnt < 8)
      begin
        shreg = {shreg[6:0], sda_i};
        bitcnt++;
      end
      else
      begin
        bitcnt = 0;
        byte_no++;
      end
    end
    else if (act && !gated && !scl_i && scl_q)
    begin
      if (bitcnt == 8 && !(rd && byte_no == 1))
      begin
        // Decode fields in order, then acknowledge or leave high
        case (byte_no)
          0:
          begin
            ack = (shreg[7:1] == 7'h44) && (refuse_i != 2'h1);
            rd = shreg[0];
            last_addr = shreg;
          end
          1:
          begin
            ack = refuse_i != 2'h2;
            idx = shreg;
          end
          default:
          begin
            ack = (refuse_i != 2'h3) && (byte_no == 2);
            if (ack && idx <= 8'h0d)
              regs[idx[3:0]] = shreg; // Writable range
          end
        endcase
        sda_oe_o = ack;
        act = ack;
      end
      else if (rd && byte_no == 1 && bitcnt < 8)
        sda_oe_o = !tx[7 - bitcnt]; // Read back without change
      else
        sda_oe_o = 1'b0; // Release for the other party
    end
    scl_q = scl_i;
    sda_q = sda_i;
  end

endmodule : scm_dev_model

`default_nettype wire

// [scm_master_tb.sv]
// Self-checking bench of the serial control master with a device model.
// Assumes the quarter-bit count shortened to 4 core cycles.
`timescale 1ns/10ps
`default_nettype none

module scm_master_tb;
  import scm_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0, sys_rst = 1'b1; // Clock and reset
  logic [3:0] bus_addr = 4'h0; // Bus address
  logic [31:0] bus_wdata = 32'h0, bus_rdata, st, d; // Bus data
  logic bus_wr = 1'b0, bus_rd = 1'b0; // Strobes
  logic scl_o, scl_oe, sda_o, sda_oe, off_pin, dev_oe; // Line controls
  logic [1:0] refuse = 2'h0; // Model refusal select
  int miscompares = 0, samples_checked = 0, n_start, n_stop; // Counters
  wire logic scl_w = scl_oe ? scl_o : 1'b1; // Pulled-up clock wire
  wire logic sda_w = (sda_oe ? sda_o : 1'b1) & !dev_oe; // Pulled-up data wire

  always #2 core_clk = ~core_clk;

  scm_master #(.QTR(4)) u_scm_master (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .bus_addr_i(bus_addr),
    .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata), .scl_o(scl_o),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .output_off_pin_o(off_pin));
  scm_dev_model u_scm_dev_model (.scl_i(scl_w), .sda_i(sda_w), .output_off_pin_i(off_pin),
    .refuse_i(refuse), .sda_oe_o(dev_oe));

  // Count start and stop conditions on the wire
  always @(negedge sda_w) if (scl_w === 1'b1) n_start++;
  always @(posedge sda_w) if (scl_w === 1'b1) n_stop++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : bus_read

  // Issue one command and wait for completion, bounded
  task automatic xfer(input logic rdn, input logic [7:0] idx, input logic [7:0] v);
    int n;
    n_start = 0;
    n_stop = 0;
    n = 0;
    bus_write(OFF_CMD, {15'h0, rdn, v, idx});
    do
    begin
      bus_read(OFF_STAT, st);
      n++;
    end while ((st[ST_BUSY_BIT] !== 1'b0 || st[ST_DONE_BIT] !== 1'b1) && n < 1000);
    chk(32'(n < 1000), 32'h1); // Finished within the poll limit
    chk({30'h0, scl_w, sda_w}, 32'h3); // Bus left idle
  endtask : xfer

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    bus_read(OFF_STAT, d);
    chk(d, 32'h0); // Idle status
    bus_read(4'hc, d);
    chk(d, 32'h0); // Unmapped place reads zero
    chk({31'h0, off_pin}, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_write_read;
    logic [7:0] ix [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h07, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] dv [9] = '{8'h16, 8'h00, 8'h35, 8'h07, 8'h81, 8'h85, 8'haa, 8'hff, 8'h85};
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b0, ix[i], dv[i]);
      chk(st & 32'hf, 32'h4); // Acknowledged write completes
      bus_read(OFF_CMD, d);
      chk(d, {16'h0, dv[i], ix[i]}); // Command held for reading back
      chk({24'h0, u_scm_dev_model.regs[ix[i][3:0]]}, {24'h0, dv[i]}); // Fields in order
      chk({24'h0, u_scm_dev_model.last_addr}, 32'h88); // Address and write bit
      chk(32'(n_start * 16 + n_stop), 32'h11); // One start and one stop
      xfer(1'b1, ix[i], 8'h00);
      chk(st & 32'hff0f, {16'h0, dv[i], 8'h04}); // Byte returned MSB first
      chk({24'h0, u_scm_dev_model.last_addr}, 32'h89); // Read direction bit
      chk(32'(n_start * 16 + n_stop), 32'h21); // Repeated start before read
      chk({24'h0, u_scm_dev_model.regs[ix[i][3:0]]}, {24'h0, dv[i]}); // Read leaves register
    end
    chk({14'h0, u_scm_dev_model.offset_cancel_off, u_scm_dev_model.output_invert,
         u_scm_dev_model.absent_range_high, u_scm_dev_model.slice_adjust_on, u_scm_dev_model.slice_span_code,
         u_scm_dev_model.deemph_code, u_scm_dev_model.rx_tuning_apply, u_scm_dev_model.rx_tuning_code,
         u_scm_dev_model.output_swing_code, u_scm_dev_model.rise_mask_enable,
         u_scm_dev_model.fall_mask_enable}, 32'h0003b5bf);
    chk({u_scm_dev_model.fall_mask_us, u_scm_dev_model.rise_mask_us}, 32'h0fe000a0);
    $display("write read test done");
  endtask : t_write_read

  task automatic t_read_only;
    xfer(1'b0, 8'h0f, 8'h11);
    chk(st & 32'hf, 32'hc); // Read-only place refused
    xfer(1'b0, 8'h0e, 8'h11);
    chk(st & 32'hf, 32'hc); // Gap above range refused
    xfer(1'b1, 8'h0e, 8'h00);
    chk(st & 32'hf, 32'hc); // Read of gap refused
    xfer(1'b1, 8'h0f, 8'h00);
    chk(st & 32'hff0f, 32'h2a04); // Code selected as level
    xfer(1'b0, 8'h0b, 8'h2a);
    xfer(1'b1, 8'h0f, 8'h00);
    chk(st & 32'hff0f, 32'h1904); // Fixed level selected
    $display("read-only test done");
  endtask : t_read_only

  task automatic t_refuse;
    for (int r = 1; r < 4; r++)
    begin
      @(posedge core_clk);
      refuse <= r[1:0];
      xfer(1'b0, 8'h01, 8'h5a);
      chk(st & 32'hf, 32'h6); // Refusal ends with nack
      chk(32'(n_stop), 32'h1); // Aborted by a stop
      chk({24'h0, u_scm_dev_model.regs[1]}, 32'h0); // Refused byte not stored
    end
    @(posedge core_clk);
    refuse <= 2'h0;
    $display("refusal test done");
  endtask : t_refuse

  task automatic t_pin;
    bus_write(OFF_PIN, 32'h3);
    bus_read(OFF_PIN, d);
    chk(d, 32'h3); // Pin control read back
    chk({31'h0, off_pin}, 32'h1); // Pin level driven
    xfer(1'b0, 8'h00, 8'h00);
    chk(st & 32'hf, 32'he); // Guarded command refused, last abort still flagged
    bus_write(OFF_PIN, 32'h0);
    xfer(1'b0, 8'h00, 8'h20);
    bus_write(OFF_PIN, 32'h1);
    xfer(1'b0, 8'h00, 8'h00);
    chk(st & 32'hf, 32'h6); // Gated clock ignored
    chk({24'h0, u_scm_dev_model.regs[0]}, 32'h20);
    bus_write(OFF_PIN, 32'h0);
    xfer(1'b0, 8'h00, 8'h00);
    chk(st & 32'hf, 32'h4); // Clock honoured again
    $display("pin test done");
  endtask : t_pin

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_write_read();
    t_read_only();
    t_refuse();
    t_pin();
    end_sim();
  end

  initial
  begin
    #300000;
    miscompares++;
    end_sim();
  end

endmodule : scm_master_tb

`default_nettype wire
